//--- rtl/rawsch_map.vh
`ifndef RAWSCH_MAP_VH
`define RAWSCH_MAP_VH
// Request word field positions
`define RAWSCH_F_WR 0
`define RAWSCH_F_ADDR_LO 1
// Chunk select bits inside the line address
`define RAWSCH_CHUNK_LO 3
`define RAWSCH_CHUNK_HI 4
// Row/column split of the DRAM address
`define RAWSCH_ROW_LO 12
// Reset values
`define RAWSCH_RST_ADDR 12'h0000
`define RAWSCH_RST_TAG 4'h0
// Timing counts in cycles
`define RAWSCH_RAS_SETUP_CYC 1
`define RAWSCH_CHUNKS 4
// Most reads the extended option lets past one parked write
`define RAWSCH_PASS_MAX 3'd7
`endif

//--- rtl/rawsch_fifo.v
`timescale 1ns/1ns
module rawsch_fifo #(
    parameter WIDTH = 40,
    parameter DEPTH = 16,
    parameter AW = 4
) (
    input wire clk_i,
    input wire nrst_i,
    input wire in_valid_i,
    output wire in_ready_o,
    input wire [WIDTH-1:0] in_data_i,
    output wire out_valid_o,
    input wire out_ready_i,
    output wire [WIDTH-1:0] out_data_o
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW:0] wp_r;
    reg [AW:0] rp_r;
    wire full = (wp_r[AW] != rp_r[AW]) && (wp_r[AW-1:0] == rp_r[AW-1:0]);
    wire empty = (wp_r == rp_r);
    assign in_ready_o = !full;
    assign out_valid_o = !empty;
    assign out_data_o = mem[rp_r[AW-1:0]];
    always @(posedge clk_i) begin
        if (in_valid_i && !full) begin
            mem[wp_r[AW-1:0]] <= in_data_i;
        end
    end
    always @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            wp_r <= {(AW+1){1'b0}};
            rp_r <= {(AW+1){1'b0}};
        end else begin
            if (in_valid_i && !full) begin
                wp_r <= wp_r + 1'b1;
            end
            if (out_ready_i && !empty) begin
                rp_r <= rp_r + 1'b1;
            end
        end
    end
endmodule // rawsch_fifo

//--- rtl/rawsch_top.v
`timescale 1ns/1ns
`include "rawsch_map.vh"
////////////////////////////////////////////////////////////////////////////////
module rawsch_top #(
    parameter AW = 24,
    parameter TW = 4,
    parameter DEPTH = 16,
    parameter DAW = 12
) (
    input wire clk_i,
    input wire nrst_i,
    input wire bypass_enable_i,
    input wire extended_read_bypass_enable_i,
    input wire req_valid_i,
    output reg req_ready_o,
    input wire req_wr_i,
    input wire [AW-1:0] req_addr_i,
    input wire [TW-1:0] req_tag_i,
    input wire snoop_done_i,
    output reg dram_ras_o,
    output reg dram_cas_o,
    output reg dram_we_o,
    output reg [DAW-1:0] dram_addr_lines_n_o,
    output reg [1:0] chunk_o,
    output reg rd_done_o,
    output reg [TW-1:0] rd_tag_o
);
    localparam W = 1 + AW + TW;
    localparam S_IDLE = 3'd0;
    localparam S_ROW = 3'd1;
    localparam S_RAS = 3'd2;
    localparam S_COL = 3'd3;
    localparam S_DATA = 3'd4;
    localparam S_PRE = 3'd5;
    localparam FAW = $clog2(DEPTH);

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers for the two enables and the snoop status
    // Levels from other agents; only the second flop of each pair is read
    wire [2:0] pin_w = {snoop_done_i, extended_read_bypass_enable_i, bypass_enable_i};
    wire [2:0] sync_w;
    genvar gs;
    generate
        for (gs = 0; gs < 3; gs = gs + 1) begin : g_sync
            reg meta_r;
            reg sync_r;
            always @(posedge clk_i or negedge nrst_i) begin
                if (!nrst_i) begin
                    meta_r <= 1'b0;
                    sync_r <= 1'b0;
                end else begin
                    meta_r <= pin_w[gs];
                    sync_r <= meta_r;
                end
            end
            assign sync_w[gs] = sync_r;
        end
    endgenerate
    wire raw_en = sync_w[0];
    // Extended reordering means nothing unless the basic option is on
    wire extended_read_bypass_enable_en = sync_w[0] & sync_w[1];
    wire snoop_ok = sync_w[2];

    ////////////////////////////////////////////////////////////////////////////
    // Request FIFO
    wire f_valid;
    wire [W-1:0] f_data;
    reg pop;
    wire in_ready;
    rawsch_fifo #(.WIDTH(W), .DEPTH(DEPTH), .AW(FAW)) u_fifo (
        .clk_i(clk_i),
        .nrst_i(nrst_i),
        .in_valid_i(req_valid_i),
        .in_ready_o(in_ready),
        .in_data_i({req_tag_i, req_addr_i, req_wr_i}),
        .out_valid_o(f_valid),
        .out_ready_i(pop),
        .out_data_o(f_data)
    );
    wire h_wr = f_data[`RAWSCH_F_WR];
    wire [AW-1:0] h_addr = f_data[`RAWSCH_F_ADDR_LO +: AW];
    wire [TW-1:0] h_tag = f_data[`RAWSCH_F_ADDR_LO + AW +: TW];

    ////////////////////////////////////////////////////////////////////////////
    // Parked write slot: one older write may wait while reads pass it
    reg pk_v_r;
    reg [AW-1:0] pk_addr_r;
    reg pk_snp_r;
    reg [2:0] pass_r;
    // Current transaction
    reg cur_wr_r;
    reg [AW-1:0] cur_addr_r;
    reg [TW-1:0] cur_tag_r;
    reg [2:0] st_r;
    reg [1:0] beat_r;
    reg [1:0] crit_r;
    reg [AW-1:0] open_row_r;
    reg row_open_r;

    // Take the parked write when a second write arrives, when bypass is off,
    // or when the basic option has already let one read by.
    wire head_is_wr = f_valid & h_wr;
    wire head_is_rd = f_valid & ~h_wr;
    // Basic option lets one read by; extended lets several, up to a fixed cap
    wire bypass_ok = raw_en &
        ((extended_read_bypass_enable_en & (pass_r != `RAWSCH_PASS_MAX)) | (pass_r == 3'd0));
    wire issue_pk = pk_v_r & pk_snp_r & (head_is_wr | ~head_is_rd | ~bypass_ok);
    wire issue_rd = head_is_rd & (~pk_v_r | bypass_ok);
    wire park_wr = head_is_wr & ~pk_v_r & raw_en;
    wire issue_wr = head_is_wr & ~pk_v_r & ~raw_en & snoop_ok;

    wire [AW-1:0] nxt_addr = issue_pk ? pk_addr_r : h_addr;
    // The hit test looks at the transaction actually chosen, not the queue head,
    // so a reordered read never inherits a strobe left open for someone else.
    wire row_hit = row_open_r &&
        (nxt_addr[AW-1:`RAWSCH_ROW_LO] == open_row_r[AW-1:`RAWSCH_ROW_LO]);
    wire take = issue_pk | issue_rd | issue_wr;

    ////////////////////////////////////////////////////////////////////////////
    // Scheduler and DRAM sequencer
    always @* begin
        pop = 1'b0;
        if (st_r == S_IDLE && !issue_pk) begin
            pop = issue_rd | park_wr | issue_wr;
        end
    end

    // The row strobe is only dropped on a row miss, so a row hit goes straight
    // to the column phase and saves the precharge and row setup.
    reg [2:0] st_nxt;
    always @* begin
        st_nxt = st_r;
        case (st_r)
            S_IDLE: begin
                if (take && row_hit && dram_ras_o) begin
                    st_nxt = S_COL;
                end else if (take && dram_ras_o) begin
                    st_nxt = S_PRE;
                end else if (take) begin
                    st_nxt = S_ROW;
                end
            end
            S_PRE: st_nxt = S_ROW;
            S_ROW: st_nxt = S_RAS;
            S_RAS: st_nxt = S_COL;
            S_COL: st_nxt = S_DATA;
            S_DATA: begin
                if (beat_r == 2'd3) begin
                    st_nxt = S_IDLE;
                end
            end
            default: st_nxt = S_IDLE;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Parked write bookkeeping; only the idle state takes or releases the slot
    always @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            pk_v_r <= 1'b0;
            pk_addr_r <= {AW{1'b0}};
            pk_snp_r <= 1'b0;
            pass_r <= 3'd0;
        end else begin
            if (pk_v_r && snoop_ok) begin
                pk_snp_r <= 1'b1;
            end
            if (st_r == S_IDLE && issue_pk) begin
                pk_v_r <= 1'b0;
                pass_r <= 3'd0;
            end else if (st_r == S_IDLE && issue_rd) begin
                if (pk_v_r && pass_r != `RAWSCH_PASS_MAX) begin
                    pass_r <= pass_r + 3'd1;
                end
            end else if (st_r == S_IDLE && park_wr) begin
                pk_v_r <= 1'b1;
                pk_addr_r <= h_addr;
                pk_snp_r <= 1'b0;
                pass_r <= 3'd0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Open row tracking
    always @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            open_row_r <= {AW{1'b0}};
            row_open_r <= 1'b0;
        end else if (st_r == S_PRE) begin
            row_open_r <= 1'b0;
        end else if (st_r == S_RAS) begin
            open_row_r <= cur_addr_r;
            row_open_r <= 1'b1;
        end
    end

    // Chunk of the current beat: crit 3 gives 3-2-1-0, crit 2 gives 2-3-0-1
    reg [1:0] beat_chunk;
    always @* begin
        beat_chunk = crit_r ^ beat_r;
    end

    // Address lines come from one mux; they hold while the row strobe rises,
    // since a change on that clock corrupts the access.
    reg [DAW-1:0] addr_nxt;
    always @* begin
        addr_nxt = dram_addr_lines_n_o;
        case (st_r)
            S_ROW: addr_nxt = ~cur_addr_r[`RAWSCH_ROW_LO +: DAW];
            S_RAS: addr_nxt = dram_addr_lines_n_o;
            S_COL: addr_nxt = ~{{(DAW-2){1'b0}}, crit_r};
            S_DATA: addr_nxt = ~{{(DAW-2){1'b0}}, beat_chunk};
            default: addr_nxt = dram_addr_lines_n_o;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Transaction capture
    always @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            st_r <= S_IDLE;
            cur_wr_r <= 1'b0;
            cur_addr_r <= {AW{1'b0}};
            cur_tag_r <= `RAWSCH_RST_TAG;
            beat_r <= 2'd0;
            crit_r <= 2'd0;
        end else begin
            st_r <= st_nxt;
            if (st_r == S_IDLE && take) begin
                cur_wr_r <= issue_pk | issue_wr;
                cur_addr_r <= nxt_addr;
                cur_tag_r <= h_tag;
                crit_r <= nxt_addr[`RAWSCH_CHUNK_HI:`RAWSCH_CHUNK_LO];
            end
            if (st_r == S_COL) begin
                beat_r <= 2'd0;
            end else if (st_r == S_DATA) begin
                beat_r <= beat_r + 2'd1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // DRAM pins, all registered
    always @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            dram_ras_o <= 1'b0;
            dram_cas_o <= 1'b0;
            dram_we_o <= 1'b0;
            dram_addr_lines_n_o <= `RAWSCH_RST_ADDR;
            chunk_o <= 2'd0;
        end else begin
            dram_cas_o <= 1'b0;
            dram_addr_lines_n_o <= addr_nxt;
            case (st_r)
                S_IDLE: begin
                    if (take && dram_ras_o && !row_hit) begin
                        dram_ras_o <= 1'b0;
                    end
                end
                S_RAS: begin
                    dram_ras_o <= 1'b1;
                end
                S_DATA: begin
                    // Critical chunk first, then the agent's interleaved order
                    chunk_o <= beat_chunk;
                    dram_cas_o <= 1'b1;
                    dram_we_o <= cur_wr_r;
                end
                default: begin
                    dram_ras_o <= dram_ras_o;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read completion and request-side ready
    always @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            req_ready_o <= 1'b0;
            rd_done_o <= 1'b0;
            rd_tag_o <= `RAWSCH_RST_TAG;
        end else begin
            // Ready lags the FIFO by a cycle; agents must keep a one-word margin
            req_ready_o <= in_ready;
            rd_done_o <= 1'b0;
            if (st_r == S_DATA && beat_r == 2'd3 && !cur_wr_r) begin
                rd_done_o <= 1'b1;
                rd_tag_o <= cur_tag_r;
            end
        end
    end
endmodule // rawsch_top

//--- verification/rawsch_dram_model.sv
`timescale 1ns/1ns
module rawsch_dram_model (
    input wire clk_i,
    input wire ras_i,
    input wire cas_i,
    input wire we_i,
    input wire [1:0] chunk_i
);
    logic [2:0] beat_q[$];
    int bad_cnt = 0;
    // Logs each column beat as {write, chunk}; the bench judges the order
    always @(posedge clk_i) begin
        if (cas_i) begin
            beat_q.push_back({we_i, chunk_i});
            if (!ras_i) bad_cnt++;
        end
    end
endmodule // rawsch_dram_model

//--- verification/rawsch_top_props.sv
`timescale 1ns/1ns
module rawsch_top_props #(parameter AW = 24, parameter TW = 4, parameter DEPTH = 16,
    parameter DAW = 12) (
    input wire clk_i,
    input wire nrst_i,
    input wire bypass_enable_i,
    input wire extended_read_bypass_enable_i,
    input wire req_valid_i,
    input wire req_ready_o,
    input wire req_wr_i,
    input wire [AW-1:0] req_addr_i,
    input wire [TW-1:0] req_tag_i,
    input wire snoop_done_i,
    input wire dram_ras_o,
    input wire dram_cas_o,
    input wire dram_we_o,
    input wire [DAW-1:0] dram_addr_lines_n_o,
    input wire [1:0] chunk_o,
    input wire rd_done_o,
    input wire [TW-1:0] rd_tag_o
);
    reg snoop_seen_r;
    // Sticky: a write beat before any snoop answer can never be legal
    always @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) snoop_seen_r <= 1'b0;
        else if (snoop_done_i) snoop_seen_r <= 1'b1;
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!nrst_i);
    ////////////////////////////////////////////////////////////////////////////////
    chk_addr_ras_sep: assert property ($rose(dram_ras_o) |-> $stable(dram_addr_lines_n_o))
        else $error("address moved with row strobe");
    chk_cas_in_row: assert property (dram_cas_o |-> dram_ras_o)
        else $error("column beat without open row");
    chk_beat_run: assert property ($rose(dram_cas_o) |-> dram_cas_o [*4])
        else $error("line burst shorter than four beats");
    chk_we_steady: assert property ($rose(dram_cas_o) |=> $stable(dram_we_o) [*3])
        else $error("write marker changed inside a line");
    chk_chunk_order: assert property ($rose(dram_cas_o) |-> ##1 (chunk_o == ($past(chunk_o) ^ 2'b01))
        ##1 (chunk_o == ($past(chunk_o) ^ 2'b11)) ##1 (chunk_o == ($past(chunk_o) ^ 2'b01)))
        else $error("chunk order not critical first");
    chk_done_last: assert property (rd_done_o |-> dram_cas_o && !dram_we_o)
        else $error("read done away from a read beat");
    chk_done_pulse: assert property (rd_done_o |=> !rd_done_o)
        else $error("read done longer than one cycle");
    chk_wr_snoop: assert property ((dram_cas_o && dram_we_o) |-> snoop_seen_r)
        else $error("write beat before snoop status");
    cover property (dram_cas_o && dram_we_o);
    cover property (rd_done_o);
    cover property ($rose(dram_ras_o));
endmodule // rawsch_top_props
bind rawsch_top rawsch_top_props #(.AW(AW), .TW(TW), .DEPTH(DEPTH), .DAW(DAW)) u_props (.*);

//--- verification/tb.sv
`timescale 1ns/1ns
module tb;
    logic clk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic byp = 1'b0, ext = 1'b0, vld = 1'b0, wr = 1'b0, snp = 1'b0;
    logic [23:0] addr = 24'h00_0000;
    logic [3:0] tag = 4'h0, last_tag = 4'h0;
    wire rdy, ras, cas, we, done;
    wire [11:0] mal;
    wire [1:0] chunk;
    wire [3:0] rtag;
    int num_errors = 0, compares = 0, cyc = 0, rd_cnt = 0;
    always #10 clk_i = ~clk_i;
    rawsch_top u_dut (.clk_i(clk_i), .nrst_i(nrst_i), .bypass_enable_i(byp),
        .extended_read_bypass_enable_i(ext), .req_valid_i(vld), .req_ready_o(rdy),
        .req_wr_i(wr), .req_addr_i(addr), .req_tag_i(tag), .snoop_done_i(snp),
        .dram_ras_o(ras), .dram_cas_o(cas), .dram_we_o(we), .dram_addr_lines_n_o(mal),
        .chunk_o(chunk), .rd_done_o(done), .rd_tag_o(rtag));
    rawsch_dram_model u_mem (.clk_i(clk_i), .ras_i(ras), .cas_i(cas), .we_i(we),
        .chunk_i(chunk));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic end_sim();
        $display("num_errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    always @(posedge clk_i) begin
        cyc++;
        if (done) begin
            rd_cnt++;
            last_tag = rtag;
        end
        if (cyc == 6000) begin
            num_errors++;
            $display("Error %0t run hung", $time);
            end_sim();
        end
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("Error %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // FIFO never nears full here, so ready is not polled
    task automatic send(input logic w, input logic [1:0] c, input logic [3:0] t);
        @(posedge clk_i);
        vld <= 1'b1;
        wr <= w;
        addr <= {12'h001, 7'h00, c, 3'h0};
        tag <= t;
        @(posedge clk_i);
        vld <= 1'b0;
    endtask
    task automatic chk_line(input logic w, input logic [1:0] c);
        logic [1:0] k;
        repeat (80) if (u_mem.beat_q.size() < 4) @(posedge clk_i);
        for (int i = 0; i < 4; i++) begin
            k = i[1:0];
            chk({5'h00, u_mem.beat_q.pop_front()}, {5'h00, w, c ^ k});
        end
        chk(mal[7:0], 8'hff ^ {6'h00, c ^ 2'b11});
        chk({4'h0, mal[11:8]}, 8'h0f);
    endtask
    task automatic s_orders();
        for (int c = 0; c < 4; c++) begin
            send(1'b1, c[1:0], 4'h0);
            chk_line(1'b1, c[1:0]);
            send(1'b0, c[1:0], c[3:0]);
            chk_line(1'b0, c[1:0]);
            repeat (4) @(posedge clk_i);
            chk({4'h0, last_tag}, {4'h0, c[3:0]});
        end
    endtask
    task automatic s_snoop();
        snp <= 1'b0;
        send(1'b1, 2'b10, 4'h0);
        repeat (40) @(posedge clk_i);
        chk(8'(u_mem.beat_q.size()), 8'h00);
        snp <= 1'b1;
        chk_line(1'b1, 2'b10);
    endtask
    task automatic s_bypass(input logic e, input int n);
        int n0;
        n0 = rd_cnt;
        snp <= 1'b0;
        byp <= 1'b1;
        ext <= e;
        send(1'b1, 2'b01, 4'h0);
        send(1'b0, 2'b00, 4'h5);
        send(1'b0, 2'b11, 4'h6);
        repeat (60) @(posedge clk_i);
        chk(8'(rd_cnt - n0), 8'(n));
        snp <= 1'b1;
        repeat (60) @(posedge clk_i);
        chk(8'(rd_cnt - n0), 8'h02);
        u_mem.beat_q.delete();
    endtask
    task automatic s_wr_order();
        logic [2:0] wq[$];
        send(1'b1, 2'b01, 4'h0);
        send(1'b0, 2'b00, 4'h7);
        send(1'b1, 2'b10, 4'h0);
        send(1'b0, 2'b11, 4'h8);
        repeat (100) @(posedge clk_i);
        foreach (u_mem.beat_q[i]) if (u_mem.beat_q[i][2]) wq.push_back(u_mem.beat_q[i]);
        chk(8'(wq.size()), 8'h08);
        chk({5'h00, wq[0]}, 8'h05);
        chk({5'h00, wq[4]}, 8'h06);
    endtask
    initial begin
        repeat (16) @(posedge clk_i);
        nrst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        chk({7'h00, rdy}, 8'h01);
        snp <= 1'b1;
        s_orders();
        s_snoop();
        s_bypass(1'b0, 1);
        s_bypass(1'b1, 2);
        s_wr_order();
        chk(8'(u_mem.bad_cnt), 8'h00);
        end_sim();
    end
endmodule // tb
